/* rihc_regs.svh */
// Register offsets, bit positions and reset values of the
// region isolation handshake controller.
// Assumes word addressing on a two-bit register address.
`ifndef RIHC_REGS_SVH
`define RIHC_REGS_SVH

// Word offsets
`define RIHC_OFS_STATUS 2'h0
`define RIHC_OFS_CTRL 2'h1
`define RIHC_OFS_BLOCKED 2'h2
`define RIHC_OFS_REV 2'h3

// Status fields
`define RIHC_ST_ISO_BIT 0
`define RIHC_ST_REL_BIT 1

// Control fields
`define RIHC_CT_ISO_BIT 0
`define RIHC_CT_RST_BIT 1
`define RIHC_CT_REL_BIT 2

// Reset values
`define RIHC_CTRL_RST 3'h0
`define RIHC_WORD_ZERO 32'h0

`endif

/* rihc_pkg.sv */
// Types shared by the region isolation handshake controller.
// Assumes the constants header is compiled alongside.
package rihc_pkg;

   // Handshake sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_HALT_WAIT,
      ST_ISOLATED,
      ST_RESUME_WAIT
   } rihc_state_t;

   // Control word, bit 2 down to bit 0
   typedef struct packed {
      logic rel;
      logic rst;
      logic iso;
   } rihc_ctrl_t;

   // Status word, bit 1 down to bit 0
   typedef struct packed {
      logic rel_done;
      logic iso_done;
   } rihc_status_t;

endpackage

/* rihc_ctrl.sv */
// Region isolation handshake controller: register bank,
// halt/resume sequencer, isolation splitter, blocked merger.
// Assumes the region and its bridges run on core_clk.
`include "rihc_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module rihc_ctrl
   import rihc_pkg::*;
#(
   parameter int NB = 4,
   // Arbitrary revision value
   parameter logic [31:0] REVISION = 32'h5A5A0001
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [1:0] csr_addr,
   input wire logic csr_read,
   input wire logic csr_write,
   input wire logic [31:0] csr_writedata,
   output logic [31:0] csr_readdata,
   output logic irq,
   output logic halt_req,
   input wire logic halt_ack,
   output logic resume_req,
   input wire logic resume_ack,
   output logic region_rst,
   output logic [NB-1:0] bridge_isolate,
   input wire logic [NB-1:0] bridge_blocked
);

   // State registers
   rihc_state_t state_q, state_d;
   rihc_ctrl_t ctrl_q, ctrl_d;
   rihc_status_t stat_q, stat_d;
   logic halt_req_q, halt_req_d;
   logic resume_req_q, resume_req_d;
   logic iso_q, iso_d;
   logic [NB-1:0] bridge_iso_q, bridge_iso_d;
   logic region_rst_q, region_rst_d;
   logic [NB-1:0] blocked_q, blocked_d;
   logic irq_q, irq_d;
   logic [31:0] rdata_q, rdata_d;

   // Decoded write strobes
   logic wr_ctrl;
   logic wr_blocked;
   rihc_ctrl_t wr_val;
   logic both_req;

   // Read word for one offset, reserved bits zero
   function automatic logic [31:0] rd_word(
      input logic [1:0] addr,
      input rihc_status_t st,
      input rihc_ctrl_t ct,
      input logic [NB-1:0] blk
   );
      logic [31:0] w;
      w = `RIHC_WORD_ZERO;
      unique case (addr)
         `RIHC_OFS_STATUS: begin
            w[1:0] = st;
         end
         `RIHC_OFS_CTRL: begin
            w[2:0] = ct;
         end
         `RIHC_OFS_BLOCKED: begin
            w[NB-1:0] = blk;
         end
         `RIHC_OFS_REV: begin
            w = REVISION;
         end
      endcase
      return w;
   endfunction

   // Address decode of the register bank
   always_comb begin
      wr_ctrl = csr_write && (csr_addr == `RIHC_OFS_CTRL);
      wr_blocked = csr_write &&
         (csr_addr == `RIHC_OFS_BLOCKED);
      wr_val = rihc_ctrl_t'(csr_writedata[2:0]);
      both_req = wr_val.iso && wr_val.rel;
   end

   // Control register next value
   always_comb begin
      ctrl_d = ctrl_q;
      // Hardware clears a request once its flag is up
      if (stat_q.iso_done) begin
         ctrl_d.iso = 1'b0;
      end
      if (stat_q.rel_done) begin
         ctrl_d.rel = 1'b0;
      end
      // Software write wins over the hardware clear, except a double request, which leaves it in place
      if (wr_ctrl) begin
         ctrl_d.rst = wr_val.rst;
         if (!both_req) begin
            ctrl_d.iso = wr_val.iso;
            ctrl_d.rel = wr_val.rel;
         end
      end
   end

   // Handshake sequencer next state and outputs
   always_comb begin
      state_d = state_q;
      stat_d = stat_q;
      halt_req_d = halt_req_q;
      resume_req_d = resume_req_q;
      iso_d = iso_q;
      unique case (state_q)
         ST_IDLE: begin
            if (ctrl_q.iso && !ctrl_q.rel) begin
               halt_req_d = 1'b1;
               stat_d.rel_done = 1'b0;
               state_d = ST_HALT_WAIT;
            end
         end
         ST_HALT_WAIT: begin
            // No timeout: only ack or abandon leave
            if (!ctrl_q.iso) begin
               halt_req_d = 1'b0;
               state_d = ST_IDLE;
            end else if (halt_ack) begin
               // Region has drained its transfers
               halt_req_d = 1'b0;
               iso_d = 1'b1;
               stat_d.iso_done = 1'b1;
               state_d = ST_ISOLATED;
            end
         end
         ST_ISOLATED: begin
            if (ctrl_q.rel && !ctrl_q.iso) begin
               iso_d = 1'b0;
               resume_req_d = 1'b1;
               stat_d.iso_done = 1'b0;
               state_d = ST_RESUME_WAIT;
            end
         end
         ST_RESUME_WAIT: begin
            // Isolation is already gone here
            if (!ctrl_q.rel) begin
               resume_req_d = 1'b0;
               state_d = ST_IDLE;
            end else if (resume_ack) begin
               resume_req_d = 1'b0;
               stat_d.rel_done = 1'b1;
               state_d = ST_IDLE;
            end
         end
      endcase
   end

   // Splitter, persona reset, merger and read data
   always_comb begin
      bridge_iso_d = {NB{iso_d}};
      region_rst_d = ctrl_d.rst;
      // Sticky: a new hit wins over a write-1 clear
      blocked_d = blocked_q;
      if (wr_blocked) begin
         blocked_d = blocked_q & ~csr_writedata[NB-1:0];
      end
      blocked_d = blocked_d | bridge_blocked;
      irq_d = |blocked_d;
      rdata_d = `RIHC_WORD_ZERO;
      if (csr_read) begin
         rdata_d = rd_word(csr_addr, stat_q, ctrl_q, blocked_q);
      end
   end

   // Register all state
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         ctrl_q <= `RIHC_CTRL_RST;
         stat_q <= '0;
         halt_req_q <= 1'b0;
         resume_req_q <= 1'b0;
         iso_q <= 1'b0;
         bridge_iso_q <= '0;
         region_rst_q <= 1'b0;
         blocked_q <= '0;
         irq_q <= 1'b0;
         rdata_q <= `RIHC_WORD_ZERO;
      end else begin
         state_q <= state_d;
         ctrl_q <= ctrl_d;
         stat_q <= stat_d;
         halt_req_q <= halt_req_d;
         resume_req_q <= resume_req_d;
         iso_q <= iso_d;
         bridge_iso_q <= bridge_iso_d;
         region_rst_q <= region_rst_d;
         blocked_q <= blocked_d;
         irq_q <= irq_d;
         rdata_q <= rdata_d;
      end
   end

   // Outputs straight from flops
   assign csr_readdata = rdata_q;
   assign irq = irq_q;
   assign halt_req = halt_req_q;
   assign resume_req = resume_req_q;
   assign region_rst = region_rst_q;
   assign bridge_isolate = bridge_iso_q;

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_halt_done;
      halt_req_q && halt_ack && ctrl_q.iso;
   endsequence

   sequence s_resume_done;
      resume_req_q && resume_ack && ctrl_q.rel;
   endsequence

   halt_raise_a: assert property (
      state_q == ST_IDLE && ctrl_q.iso && !ctrl_q.rel
      |=> halt_req_q)
      else $error("halt request not raised");

   halt_wait_a: assert property (
      halt_req_q && !halt_ack && ctrl_q.iso |=> halt_req_q)
      else $error("halt request dropped without ack");

   halt_drop_a: assert property (
      s_halt_done |=> !halt_req_q)
      else $error("halt request held after ack");

   isolate_on_a: assert property (
      s_halt_done |=> (&bridge_isolate) ##1 (&bridge_isolate))
      else $error("isolation not asserted after ack");

   iso_flag_a: assert property (
      $rose(stat_q.iso_done) |-> $past(halt_ack) && iso_q)
      else $error("isolated flag without ack");

   resume_raise_a: assert property (
      $fell(iso_q) |-> resume_req_q && !(|bridge_isolate))
      else $error("resume request not raised");

   resume_drop_a: assert property (
      s_resume_done |=> !resume_req_q && stat_q.rel_done)
      else $error("resume request held after ack");

   rel_flag_a: assert property (
      $rose(stat_q.rel_done) |-> $past(resume_ack))
      else $error("released flag without ack");

   reset_follow_a: assert property (
      $changed(region_rst_q)
      |-> $past(csr_write && csr_addr == `RIHC_OFS_CTRL))
      else $error("persona reset moved on its own");

   split_copy_a: assert property (
      (&bridge_isolate) || !(|bridge_isolate))
      else $error("isolation copies differ");

   blocked_catch_a: assert property (
      |bridge_blocked
      |=> (blocked_q & $past(bridge_blocked))
      == $past(bridge_blocked) && irq_q)
      else $error("blocked access not caught");

   status_zero_a: assert property (
      csr_read && csr_addr == `RIHC_OFS_STATUS
      |=> csr_readdata[31:2] == '0)
      else $error("status reserved bits set");

   rev_read_a: assert property (
      csr_read && csr_addr == `RIHC_OFS_REV
      |=> csr_readdata == REVISION)
      else $error("revision word wrong");

   iso_bit_clear_a: assert property (
      stat_q.iso_done && !wr_ctrl |=> !ctrl_q.iso)
      else $error("isolate request not cleared");

   // A double request keeps the old bits, less any hardware clear
   both_ignored_a: assert property (
      wr_ctrl && both_req
      |=> ctrl_q.iso == ($past(ctrl_q.iso) && !$past(stat_q.iso_done))
      && ctrl_q.rel == ($past(ctrl_q.rel) && !$past(stat_q.rel_done)))
      else $error("double request accepted");

   irq_level_a: assert property (
      irq_q == (|blocked_q))
      else $error("irq does not match flags");

endmodule

`default_nettype wire

/* rihc_region_model.sv */
// Behavioural region persona and bridges facing the controller.
// Assumes one shared clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module rihc_region_model (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic halt_req,
   input wire logic resume_req,
   input wire logic [3:0] bridge_isolate,
   input wire logic [7:0] dly,
   input wire logic mute,
   input wire logic [3:0] hit,
   output logic halt_ack,
   output logic resume_ack,
   output logic [3:0] bridge_blocked
);
   logic [7:0] cnt;
   // Drain outstanding transfers for dly cycles, then acknowledge
   always @(posedge core_clk) begin
      if (sys_rst || !(halt_req || resume_req)) begin
         cnt <= 8'h00;
         halt_ack <= 1'b0;
         resume_ack <= 1'b0;
      end else if (cnt == dly) begin
         halt_ack <= halt_req & ~mute;
         resume_ack <= resume_req & ~mute;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
   // Bridges flag a request that arrives while isolated
   always @(posedge core_clk) begin
      bridge_blocked <= sys_rst ? 4'h0 : (hit & bridge_isolate);
   end
endmodule
`default_nettype wire

/* test_region_isolation_handshake_ctrl.sv */
// Self-checking bench of the region isolation handshake controller.
// Assumes the design files and the region model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_region_isolation_handshake_ctrl;
   import rihc_pkg::*;
   localparam logic [31:0] REV = 32'h1234ABCD; // Arbitrary value
   logic core_clk, sys_rst, csr_read, csr_write, irq, halt_req, halt_ack;
   logic resume_req, resume_ack, region_rst, mute, rd_taken;
   logic [1:0] csr_addr;
   logic [31:0] csr_writedata, csr_readdata, seed, r, exp_q[$];
   logic [3:0] bridge_isolate, bridge_blocked, hit, mask;
   logic [7:0] dly;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;

   rihc_ctrl #(.NB(4), .REVISION(REV)) u_dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .csr_addr(csr_addr),
      .csr_read(csr_read), .csr_write(csr_write),
      .csr_writedata(csr_writedata), .csr_readdata(csr_readdata),
      .irq(irq), .halt_req(halt_req), .halt_ack(halt_ack),
      .resume_req(resume_req), .resume_ack(resume_ack),
      .region_rst(region_rst), .bridge_isolate(bridge_isolate),
      .bridge_blocked(bridge_blocked));
   rihc_region_model u_region (
      .core_clk(core_clk), .sys_rst(sys_rst), .halt_req(halt_req),
      .resume_req(resume_req), .bridge_isolate(bridge_isolate),
      .dly(dly), .mute(mute), .hit(hit), .halt_ack(halt_ack),
      .resume_ack(resume_ack), .bridge_blocked(bridge_blocked));

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic stop_test();
      if (n_fail == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic cmp_bit(input string nm, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic cmp_word(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Register bus cycles, one strobe cycle each
   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      @(negedge core_clk);
      csr_addr = a;
      csr_writedata = d;
      csr_write = 1'b1;
      @(negedge core_clk);
      csr_write = 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, input logic [31:0] e);
      @(negedge core_clk);
      csr_addr = a;
      csr_read = 1'b1;
      exp_q.push_back(e);
      @(negedge core_clk);
      csr_read = 1'b0;
   endtask

   // Bounded wait for a handshake level
   task automatic wait_for(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      cmp_bit("handshake", v, s);
   endtask

   // Read answers matched against the oldest note
   always @(posedge core_clk) rd_taken <= csr_read;
   always @(negedge core_clk) begin
      if (rd_taken === 1'b1) begin
         cmp_word("csr_readdata", exp_q.pop_front(), csr_readdata);
      end
   end

   // Hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         stop_test();
      end
   end

   initial begin
      seed = 32'h000005E1;
      sys_rst = 1'b1;
      csr_read = 1'b0;
      csr_write = 1'b0;
      csr_addr = 2'h0;
      csr_writedata = 32'h0;
      hit = 4'h0;
      mute = 1'b0;
      r = rnd();
      dly = 8'h30 | {4'h0, r[3:0]};
      repeat (16) @(negedge core_clk);
      sys_rst = 1'b0;
      // Reset values and read-only words
      rd(2'h0, 32'h0);
      rd(2'h1, 32'h0);
      rd(2'h2, 32'h0);
      rd(2'h3, REV);
      wr(2'h3, rnd());
      wr(2'h0, rnd());
      rd(2'h3, REV);
      rd(2'h0, 32'h0);
      // Isolate against a slow region
      wr(2'h1, 32'h1);
      wait_for(halt_req, 1'b1);
      repeat (30) @(negedge core_clk);
      cmp_bit("halt_req", 1'b1, halt_req);
      cmp_bit("isolate", 1'b0, bridge_isolate[0]);
      wait_for(halt_req, 1'b0);
      cmp_word("isolate", 32'hF, {28'h0, bridge_isolate});
      rd(2'h0, 32'h1);
      rd(2'h1, 32'h0);
      // Blocked access while isolated
      r = rnd();
      mask = r[3:0] | 4'h1;
      @(negedge core_clk);
      hit = mask;
      @(negedge core_clk);
      hit = 4'h0;
      @(negedge core_clk);
      cmp_bit("irq", 1'b1, irq);
      rd(2'h2, {28'h0, mask});
      wr(2'h2, {28'h0, mask});
      rd(2'h2, 32'h0);
      cmp_bit("irq", 1'b0, irq);
      // Persona reset, then both requests at once
      wr(2'h1, 32'h2);
      @(negedge core_clk);
      cmp_bit("region_rst", 1'b1, region_rst);
      wr(2'h1, 32'h5);
      @(negedge core_clk);
      cmp_bit("resume_req", 1'b0, resume_req);
      cmp_bit("isolate", 1'b1, bridge_isolate[0]);
      cmp_bit("region_rst", 1'b0, region_rst);
      // Release with reset held
      dly = 8'h03;
      wr(2'h1, 32'h6);
      wait_for(resume_req, 1'b1);
      cmp_bit("isolate", 1'b0, bridge_isolate[0]);
      wait_for(resume_req, 1'b0);
      rd(2'h0, 32'h2);
      rd(2'h1, 32'h2);
      cmp_bit("region_rst", 1'b1, region_rst);
      // Abandon a halt that is never acknowledged
      mute = 1'b1;
      wr(2'h1, 32'h1);
      wait_for(halt_req, 1'b1);
      repeat (80) @(negedge core_clk);
      wr(2'h1, 32'h0);
      @(negedge core_clk);
      cmp_bit("halt_req", 1'b0, halt_req);
      cmp_bit("isolate", 1'b0, bridge_isolate[0]);
      rd(2'h0, 32'h0);
      // Isolate again, then abandon a release never answered
      mute = 1'b0;
      dly = 8'h02;
      wr(2'h1, 32'h1);
      wait_for(halt_req, 1'b1);
      wait_for(halt_req, 1'b0);
      mute = 1'b1;
      wr(2'h1, 32'h4);
      wait_for(resume_req, 1'b1);
      repeat (20) @(negedge core_clk);
      cmp_bit("resume_req", 1'b1, resume_req);
      wr(2'h1, 32'h0);
      @(negedge core_clk);
      cmp_bit("resume_req", 1'b0, resume_req);
      cmp_bit("isolate", 1'b0, bridge_isolate[0]);
      rd(2'h0, 32'h0);
      repeat (2) @(negedge core_clk);
      stop_test();
   end
endmodule
`default_nettype wire
